/* rtl/card_unit_defs.vh */
// Purpose: Shared constants for the card unit switch and indicator block
// Assumes: 10 MHz pclk, APB byte addresses, 32-bit data
// Notes:   Offsets, field positions, codes and timing figures live here only
`ifndef CARD_UNIT_DEFS_VH
`define CARD_UNIT_DEFS_VH

// Register byte addresses
`define ADDR_CONFIG      12'h000
`define ADDR_STATUS      12'h004
`define ADDR_IRQ_STATUS  12'h008
`define ADDR_IRQ_CLEAR   12'h00c
`define ADDR_IRQ_ENABLE  12'h010
`define ADDR_CONTROL     12'h014

// Switch pin positions in the switch vector (pin N sits at bit N-1)
`define PIN_LEVEL        0
`define PIN_TRIG         1
`define PIN_SLOT         2
`define PIN_LAYOUT       3
`define PIN_MODE_LO      4
`define PIN_MODE_HI      5
`define SW_RESET         6'h00

// Startup mode codes, {pin 6, pin 5}
`define MODE_NORMAL      2'h0
`define MODE_XFER        2'h1
`define MODE_FORMAT      2'h2
`define MODE_BAD         2'h3

// Restart input positions: bit 11 of the word for level 0, bit 10 for level 1
`define RST_L0           1
`define RST_L1           0

// Recognised status word bit positions per level
`define SW_BIT_L0        1
`define SW_BIT_L1        4

// Control register fields
`define CTRL_SOFT_RST    0
`define CTRL_RECOG       1

// Configuration read fields
`define CFG_LOADED       0
`define CFG_MODE_LO      1
`define CFG_MODE_HI      2
`define CFG_LAYOUT       3
`define CFG_SLOT         4
`define CFG_LEVEL        5
`define CFG_PINS_LO      8
`define CFG_PINS_HI      13

// Status read fields
`define STS_STATE_LO     0
`define STS_STATE_HI     1
`define STS_RUN          2
`define STS_ERR          3
`define STS_SLOT1        4
`define STS_SLOT2        5
`define STS_FMT          6
`define STS_WORD_LO      16
`define STS_WORD_HI      31

// Event bit positions and width
`define EV_FMT_START     0
`define EV_FMT_DONE      1
`define EV_ERROR         2
`define EV_RESTART       3
`define EV_W             4

// Timing: flash half period of 250 ms at 10 MHz, sized to the counter
`define FLASH_HALF_CYC   22'h2625a0
`define SETTLE_CYCLES    2'h3

`endif

/* rtl/pin_sync.v */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs asynchronous to pclk; clk_en freezes all stages
// Notes:   Output changes only when stages two and three agree
`default_nettype none

module pin_sync #(
  parameter W = 8
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_out
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // Stage one feeds stage two only; agreement filters single-stage glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= {W{1'b0}};
      s2_r    <= {W{1'b0}};
      s3_r    <= {W{1'b0}};
      pin_out <= {W{1'b0}};
    end else if (clk_en) begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      pin_out <= (s2_r & s3_r) | (pin_out & (s2_r ^ s3_r)) | (pin_out & s2_r & s3_r);
    end
  end

endmodule // pin_sync

`default_nettype wire

/* rtl/card_unit_switch_and_indicators.v */
// Purpose: Switch decode, format trigger and indicator drive of a card unit
// Assumes: 10 MHz pclk, APB slave with one wait state, pins are asynchronous
// Notes:   Activity inputs come from same-clock logic and are not synchronised
//
// Functional notes
// - Pins 6,5: OFF/OFF normal, OFF/ON file transfer, ON/OFF formatting.
// - Pin 4 OFF picks table file layout, ON picks flash-card layout.
// - Pin 3 OFF formats slot 1, ON formats slot 2.
// - Any change of pin 2 starts formatting the selected card; the code acts only on the first change after a load, later ones are ignored.
// - Pin 2 changes are ignored outside formatting mode.
// - Pin 1 OFF gives level 1, ON gives level 0.
// - Switch settings take effect only at start or restart; the power-up load samples the synchroniser early, reading all pins OFF.
// - Format light flashes waiting, lit while formatting, off when done.
// - Slot light of the card being formatted flashes while formatting.
// - Slot lights follow socket 1 and socket 2 access.
// - Run light steady while operational or transferring files.
// - Run light flashes on controller data moves, dark during card swap.
// - Error light on internal error or bad network setup or card.
// - All pins OFF by default: normal, table layout, slot 1, level 1.
// - Falling restart bit 11 (level 0) or 10 (level 1) restarts, reloads.
// - Recognised bit in status word: bit 1 at level 0, bit 4 at level 1.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`default_nettype none
`include "card_unit_defs.vh"

module card_unit_switch_and_indicators #(
  parameter [21:0] FLASH_HALF_CYCLES = `FLASH_HALF_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  switch_pins,
  input  wire [1:0]  restart_request_word,
  input  wire        socket1_access,
  input  wire        socket2_access,
  input  wire        unit_operational,
  input  wire        file_transfer_active,
  input  wire        cpu_data_xfer,
  input  wire        card_swap,
  input  wire        internal_error,
  input  wire        net_in_use,
  input  wire        net_setup_bad,
  input  wire        net_card_missing,
  input  wire        format_done,
  output reg         format_start,
  output reg         format_slot_two,
  output reg         format_flash_layout,
  output reg  [1:0]  startup_mode,
  output reg         level_zero,
  output reg  [15:0] unit_recognised_status_word,
  output reg         run_light,
  output reg         error_light,
  output reg         slot_one_access_light,
  output reg         slot_two_access_light,
  output reg         format_light,
  output reg         irq
);

  // Format sequence states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_BUSY = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  wire [5:0]  sw_s;
  wire [1:0]  rst_s;
  reg  [1:0]  rst_prev_r;
  reg         trig_prev_r;
  reg  [1:0]  settle_r;
  reg         load_pend_r;
  reg         loaded_r;
  reg  [1:0]  fmt_state_r;
  reg  [1:0]  fmt_state_nxt;
  reg  [21:0] flash_cnt_r;
  reg         phase_r;
  reg  [`EV_W-1:0] irq_stat_r;
  reg  [`EV_W-1:0] irq_en_r;
  reg         recog_r;
  reg  [31:0] rdata_nxt;
  reg         hit_nxt;
  reg         run_nxt;
  reg         err_nxt;
  reg  [15:0] sw_word_nxt;

  wire        setup_ph;
  wire        acc_ph;
  wire        wr_acc;
  wire        do_load;
  wire        trig_toggle;
  wire        restart_ev;
  wire        soft_rst;
  wire [`EV_W-1:0] events;

  // Light is the flash phase when flashing, else the steady level
  function blink;
    input on;
    input flash;
    input phase;
    begin
      blink = flash ? phase : on;
    end
  endfunction

  // Address match against the low address bits
  function addr_is;
    input [11:0] a;
    input [11:0] reg_addr;
    begin
      addr_is = (a == reg_addr);
    end
  endfunction

  // Switch pins and restart bits come from outside pclk
  pin_sync #(
    .W(8)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pin_in  ({restart_request_word, switch_pins}),
    .pin_out ({rst_s, sw_s})
  );

  // APB phases; one wait state so read data comes from a flop
  assign setup_ph = psel & penable & ~pready;
  assign acc_ph   = psel & penable & pready;
  assign wr_acc   = acc_ph & pwrite;
  assign soft_rst = wr_acc & addr_is(paddr, `ADDR_CONTROL) & pwdata[`CTRL_SOFT_RST];

  // Load waits three enabled cycles after reset, one short of the four the synchroniser needs to fill
  assign do_load = load_pend_r & (settle_r == `SETTLE_CYCLES);

  // Restart on the falling edge of the current level's bit, or by software
  assign restart_ev = loaded_r & ~load_pend_r & (soft_rst |
                      (level_zero ? (rst_prev_r[`RST_L0] & ~rst_s[`RST_L0])
                                  : (rst_prev_r[`RST_L1] & ~rst_s[`RST_L1])));

  // Either edge of pin 2 counts, only in formatting mode
  assign trig_toggle = loaded_r & (startup_mode == `MODE_FORMAT) &
                       (sw_s[`PIN_TRIG] != trig_prev_r);

  assign events = {restart_ev,
                   err_nxt & ~error_light,
                   (fmt_state_r == ST_BUSY) & format_done,
                   format_start};

  // Power-up and restart sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r    <= 2'h0;
      load_pend_r <= 1'b1;
      loaded_r    <= 1'b0;
      rst_prev_r  <= 2'h0;
      trig_prev_r <= 1'b0;
    end else if (clk_en) begin
      rst_prev_r  <= rst_s;
      trig_prev_r <= sw_s[`PIN_TRIG];
      if (settle_r != `SETTLE_CYCLES)
        settle_r <= settle_r + 2'h1;
      if (restart_ev) begin
        load_pend_r <= 1'b1;
      end else if (do_load) begin
        load_pend_r <= 1'b0;
        loaded_r    <= 1'b1;
      end
    end
  end

  // Configuration latch: captured only at load, so running changes are held off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_mode        <= `MODE_NORMAL;
      format_flash_layout <= 1'b0;
      format_slot_two     <= 1'b0;
      level_zero          <= 1'b0;
    end else if (clk_en && do_load) begin
      startup_mode        <= {sw_s[`PIN_MODE_HI], sw_s[`PIN_MODE_LO]};
      format_flash_layout <= sw_s[`PIN_LAYOUT];
      format_slot_two     <= sw_s[`PIN_SLOT];
      level_zero          <= sw_s[`PIN_LEVEL];
    end
  end

  // Format sequence; the done state holds until power cycle or restart
  always @* begin
    fmt_state_nxt = fmt_state_r;
    if (do_load) begin
      fmt_state_nxt = ({sw_s[`PIN_MODE_HI], sw_s[`PIN_MODE_LO]} == `MODE_FORMAT) ?
                      ST_WAIT : ST_IDLE;
    end else begin
      case (fmt_state_r)
        ST_IDLE: fmt_state_nxt = ST_IDLE;
        ST_WAIT: begin
          if (trig_toggle)
            fmt_state_nxt = ST_BUSY;
        end
        ST_BUSY: begin
          if (format_done)
            fmt_state_nxt = ST_DONE;
        end
        ST_DONE: fmt_state_nxt = ST_DONE;
        default: fmt_state_nxt = ST_IDLE;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_state_r  <= ST_IDLE;
      format_start <= 1'b0;
    end else if (clk_en) begin
      fmt_state_r  <= fmt_state_nxt;
      format_start <= ~do_load & (fmt_state_r == ST_WAIT) & trig_toggle;
    end
  end

  // Shared flash timebase for every flashing light
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_r <= 22'h000000;
      phase_r     <= 1'b0;
    end else if (clk_en) begin
      if (flash_cnt_r == FLASH_HALF_CYCLES - 22'h000001) begin
        flash_cnt_r <= 22'h000000;
        phase_r     <= ~phase_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 22'h000001;
      end
    end
  end

  // Run and error levels; a card swap blanks the run light
  always @* begin
    run_nxt = 1'b0;
    if (!card_swap)
      run_nxt = blink(unit_operational | file_transfer_active,
                      cpu_data_xfer, phase_r);
    err_nxt = internal_error |
              (net_in_use & (net_setup_bad | net_card_missing)) |
              (loaded_r & (startup_mode == `MODE_BAD));
  end

  // Bit drops while a reload is pending, so no stale level position shows
  always @* begin
    sw_word_nxt = 16'h0000;
    if (recog_r && loaded_r && !load_pend_r) begin
      if (level_zero)
        sw_word_nxt[`SW_BIT_L0] = 1'b1;
      else
        sw_word_nxt[`SW_BIT_L1] = 1'b1;
    end
  end

  // Indicator and status flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_light                   <= 1'b0;
      error_light                 <= 1'b0;
      slot_one_access_light       <= 1'b0;
      slot_two_access_light       <= 1'b0;
      format_light                <= 1'b0;
      unit_recognised_status_word <= 16'h0000;
    end else if (clk_en) begin
      run_light   <= run_nxt;
      error_light <= err_nxt;
      format_light <= blink(fmt_state_r == ST_BUSY,
                            fmt_state_r == ST_WAIT, phase_r);
      slot_one_access_light <= blink(socket1_access,
                                     (fmt_state_r == ST_BUSY) & ~format_slot_two,
                                     phase_r);
      slot_two_access_light <= blink(socket2_access,
                                     (fmt_state_r == ST_BUSY) & format_slot_two,
                                     phase_r);
      unit_recognised_status_word <= sw_word_nxt;
    end
  end

  // Sticky events: a set in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= {`EV_W{1'b0}};
      irq_en_r   <= {`EV_W{1'b0}};
      recog_r    <= 1'b0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr_acc && addr_is(paddr, `ADDR_IRQ_CLEAR))
        irq_stat_r <= (irq_stat_r & ~pwdata[`EV_W-1:0]) | events;
      else
        irq_stat_r <= irq_stat_r | events;
      if (wr_acc && addr_is(paddr, `ADDR_IRQ_ENABLE))
        irq_en_r <= pwdata[`EV_W-1:0];
      if (wr_acc && addr_is(paddr, `ADDR_CONTROL))
        recog_r <= pwdata[`CTRL_RECOG];
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data
  always @* begin
    rdata_nxt = 32'h00000000;
    hit_nxt   = 1'b1;
    case (paddr)
      `ADDR_CONFIG: begin
        rdata_nxt[`CFG_LOADED]               = loaded_r;
        rdata_nxt[`CFG_MODE_HI:`CFG_MODE_LO] = startup_mode;
        rdata_nxt[`CFG_LAYOUT]               = format_flash_layout;
        rdata_nxt[`CFG_SLOT]                 = format_slot_two;
        rdata_nxt[`CFG_LEVEL]                = level_zero;
        rdata_nxt[`CFG_PINS_HI:`CFG_PINS_LO] = sw_s;
      end
      `ADDR_STATUS: begin
        rdata_nxt[`STS_STATE_HI:`STS_STATE_LO] = fmt_state_r;
        rdata_nxt[`STS_RUN]                    = run_light;
        rdata_nxt[`STS_ERR]                    = error_light;
        rdata_nxt[`STS_SLOT1]                  = slot_one_access_light;
        rdata_nxt[`STS_SLOT2]                  = slot_two_access_light;
        rdata_nxt[`STS_FMT]                    = format_light;
        rdata_nxt[`STS_WORD_HI:`STS_WORD_LO]   = unit_recognised_status_word;
      end
      `ADDR_IRQ_STATUS: rdata_nxt[`EV_W-1:0] = irq_stat_r;
      `ADDR_IRQ_CLEAR:  rdata_nxt = 32'h00000000;
      `ADDR_IRQ_ENABLE: rdata_nxt[`EV_W-1:0] = irq_en_r;
      `ADDR_CONTROL:    rdata_nxt[`CTRL_RECOG] = recog_r;
      default:          hit_nxt = 1'b0;
    endcase
  end

  // Bus answer: ready rises one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_nxt;
      if (setup_ph && !pwrite)
        prdata <= rdata_nxt;
    end
  end

endmodule // card_unit_switch_and_indicators

`default_nettype wire

/* testbench/card_unit_checker.sv */
// Purpose: Port assertions for the switch and indicator block
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Bound by name onto the top module
`default_nettype none
module card_unit_checker #(
  parameter [21:0] FLASH_HALF_CYCLES = 22'h4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic [1:0]  startup_mode,
  input wire logic        error_light,
  input wire logic        internal_error,
  input wire logic        socket1_access,
  input wire logic        slot_one_access_light,
  input wire logic        format_start,
  input wire logic        format_light,
  input wire logic        unit_operational,
  input wire logic        cpu_data_xfer,
  input wire logic        card_swap,
  input wire logic        run_light,
  input wire logic [15:0] unit_recognised_status_word,
  input wire logic        level_zero,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Lights lag their causes by one enabled edge
  property p_bad_mode; clk_en && startup_mode == 2'h3 |=> error_light; endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("error light off in bad mode");
  property p_int_err; clk_en && internal_error |=> error_light; endproperty
  a_int_err: assert property (p_int_err) else $error("error light missed");
  property p_slot1; clk_en && startup_mode == 2'h0 && socket1_access |=> slot_one_access_light;
  endproperty
  a_slot1: assert property (p_slot1) else $error("slot one light missed");
  property p_fmt_mode; format_start |-> startup_mode == 2'h2; endproperty
  a_fmt_mode: assert property (p_fmt_mode) else $error("format outside format mode");
  property p_fmt_lit; format_start |-> ##[1:2] format_light; endproperty
  a_fmt_lit: assert property (p_fmt_lit) else $error("format light not lit");
  property p_run;
    clk_en && startup_mode == 2'h0 && unit_operational && !cpu_data_xfer && !card_swap
      |=> run_light;
  endproperty
  a_run: assert property (p_run) else $error("run light not steady");
  property p_swap; clk_en && card_swap |=> !run_light; endproperty
  a_swap: assert property (p_swap) else $error("run light on during swap");
  // Only the bit of the latched level may be set
  property p_recog;
    |unit_recognised_status_word |->
      unit_recognised_status_word == (level_zero ? 16'h0002 : 16'h0010);
  endproperty
  a_recog: assert property (p_recog) else $error("wrong recognised bit");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready longer than one cycle");

  c_fmt: cover property (format_start ##1 format_light);
  c_bad: cover property (startup_mode == 2'h3 ##1 error_light);
  c_swap: cover property (card_swap ##1 !run_light);
endmodule // card_unit_checker

bind card_unit_switch_and_indicators card_unit_checker #(
  .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
) u_card_unit_checker (.*);
`default_nettype wire

/* testbench/cpu_side_model.sv */
// Purpose: Controller side model driving the restart word and data moves
// Assumes: Requests change just after a rising pclk edge
// Notes:   Restart is the falling edge of the bit of the latched level
`default_nettype none
`include "card_unit_defs.vh"
module cpu_side_model (
  input  wire logic       pclk,
  output logic      [1:0] restart_request_word,
  output logic            cpu_data_xfer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    restart_request_word = 2'h0;
    cpu_data_xfer = 1'b0;
  end

  // Held ON long enough for the pin synchroniser, then dropped
  task automatic restart(input logic lvl0);
    @(posedge pclk);
    restart_request_word[lvl0 ? `RST_L0 : `RST_L1] <= 1'b1;
    repeat (6) @(posedge pclk);
    restart_request_word <= 2'h0;
    repeat (10) @(posedge pclk);
  endtask

  // One data move between unit and controller, held for c cycles
  task automatic data_move(input int c);
    @(posedge pclk);
    cpu_data_xfer <= 1'b1;
    repeat (c) @(posedge pclk);
    cpu_data_xfer <= 1'b0;
  endtask
endmodule // cpu_side_model
`default_nettype wire

/* testbench/card_unit_switch_and_indicators_tb.sv */
// Purpose: Directed bench for switch decode, format trigger and lights
// Assumes: APB slave answers within a few cycles, clk_en held high
// Notes:   Flash half period shortened to 4 cycles
`default_nettype none
`include "card_unit_defs.vh"
module card_unit_switch_and_indicators_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [21:0] FH = 22'h4;
  localparam logic [5:0] PINS [3] = '{6'h10, 6'h30, 6'h2c};
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [5:0]  switch_pins;
  logic [1:0]  restart_request_word, startup_mode;
  logic        socket1_access, socket2_access, unit_operational, file_transfer_active;
  logic        cpu_data_xfer, card_swap, internal_error, net_in_use, net_setup_bad;
  logic        net_card_missing, format_done, format_start, format_slot_two;
  logic        format_flash_layout, level_zero, run_light, error_light, irq;
  logic        slot_one_access_light, slot_two_access_light, format_light;
  logic [15:0] unit_recognised_status_word;
  int          num_errors, cmp_count, i, n;

  card_unit_switch_and_indicators #(.FLASH_HALF_CYCLES(FH)) u_card_unit_switch_and_indicators (.*);
  cpu_side_model u_cpu_side_model (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge pclk);
    if (k == 20) begin
      num_errors++;
      results();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // Latched configuration against the pins seen at the last load
  task automatic chk_cfg;
    rd(`ADDR_CONFIG, {18'h0, switch_pins, 2'h0, switch_pins[0], switch_pins[2],
       switch_pins[3], switch_pins[5:4], 1'b1});
    chk({startup_mode, level_zero, format_slot_two, format_flash_layout},
        {switch_pins[5:4], switch_pins[0], switch_pins[2], switch_pins[3]});
  endtask

  task automatic cnt_hi(input int sel);
    n = 0;
    repeat (2 * FH + 4) begin
      @(posedge pclk);
      n += (sel == 0) ? format_light : (sel == 1) ? slot_two_access_light :
           (sel == 2) ? format_start : run_light;
    end
  endtask

  initial begin
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata, switch_pins} = '0;
    {socket1_access, socket2_access, unit_operational, file_transfer_active} = '0;
    {card_swap, internal_error, net_in_use, net_setup_bad, net_card_missing} = '0;
    format_done = 1'b0;
    clk_en = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    rq = '0;
    cyc(4);
    presetn <= 1'b1;
    repeat (20) if (rq[0] !== 1'b1) apb(1'b0, `ADDR_CONFIG, 32'h0);
    chk_cfg();
    $display("defaults done");
    // Lights in normal mode
    unit_operational <= 1'b1;
    socket1_access <= 1'b1;
    socket2_access <= 1'b1;
    cyc(2);
    chk({run_light, slot_one_access_light, slot_two_access_light}, 3'h7);
    unit_operational <= 1'b0;
    file_transfer_active <= 1'b1;
    card_swap <= 1'b1;
    cyc(2);
    chk(run_light, 1'b0);
    card_swap <= 1'b0;
    internal_error <= 1'b1;
    cyc(2);
    chk({run_light, error_light}, 2'h3);
    internal_error <= 1'b0;
    net_in_use <= 1'b1;
    net_card_missing <= 1'b1;
    cyc(2);
    chk(error_light, 1'b1);
    net_card_missing <= 1'b0;
    net_setup_bad <= 1'b1;
    cyc(2);
    chk(error_light, 1'b1);
    {net_in_use, net_setup_bad, socket1_access, socket2_access} <= '0;
    cyc(2);
    chk(error_light, 1'b0);
    // Controller data moves flash the run light
    fork
      u_cpu_side_model.data_move(2 * FH + 4);
      cnt_hi(3);
    join
    chk(n > 0 && n < 12, 1'b1);
    $display("lights done");
    // Pins changed while running stay unlatched
    switch_pins <= 6'h2e;
    cyc(10);
    rd(`ADDR_CONFIG, 32'h00002e01);
    for (i = 0; i < 3; i++) begin
      switch_pins <= PINS[i];
      cyc(8);
      u_cpu_side_model.restart(level_zero);
      chk_cfg();
      if (i == 1) chk(error_light, 1'b1);
    end
    $display("modes done");
    // Format run with interrupt
    apb(1'b1, `ADDR_IRQ_CLEAR, 32'hf);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h2);
    cnt_hi(0);
    chk(n > 0 && n < 12, 1'b1);
    switch_pins <= 6'h2e;
    for (i = 0; i < 20 && format_start !== 1'b1; i++) cyc(1);
    chk(format_start, 1'b1);
    if (i == 20) results();
    switch_pins <= 6'h2c;
    cnt_hi(2);
    chk(n, 0);
    cnt_hi(1);
    chk(n > 0 && n < 12, 1'b1);
    cnt_hi(0);
    chk(n, 12);
    format_done <= 1'b1;
    cyc(4);
    chk({format_light, irq}, 2'h1);
    rd(`ADDR_IRQ_STATUS, 32'h3);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h2);
    apb(1'b1, `ADDR_IRQ_CLEAR, 32'h2);
    cyc(2);
    chk(irq, 1'b0);
    rd(`ADDR_IRQ_STATUS, 32'h1);
    rd(`ADDR_IRQ_CLEAR, 32'h0);
    format_done <= 1'b0;
    $display("format done");
    // Recognition follows the level; level changed only across a restart
    apb(1'b1, `ADDR_CONTROL, 32'h2);
    cyc(3);
    chk(unit_recognised_status_word, 16'h0010);
    switch_pins <= 6'h01;
    cyc(8);
    u_cpu_side_model.restart(level_zero);
    chk_cfg();
    chk(unit_recognised_status_word, 16'h0002);
    $display("level done");
    apb(1'b0, 12'h020, 32'h0);
    chk(re, 1'b1);
    chk(rq, 32'h0);
    apb(1'b1, `ADDR_CONFIG, 32'hffffffff);
    chk_cfg();
    $display("bus done");
    results();
  end
endmodule // card_unit_switch_and_indicators_tb
`default_nettype wire
